// file: rtl/rpot_timer.sv
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Function
// - PWM mode counts down, loads first value, then alternates second and first.
// - Each PWM phase lasts its reload value plus one count ticks.
// - Writing enable bit low halts the counter immediately.
// - PWM output is inverted level at start and even underflows, level at odd.
// - PWM mode requests at each even underflow.
// - An all-ones phase gives 0% or 100% duty, requests still raised.
// - Reload fields update on write and read back as written.
// - Loading the first value copies the second value into its buffer.
// - Software disable beats external enable in the same cycle.
// - Counter reads the new reload value at underflow, minus one next tick.
// - Output may change up to one count tick after enable.
// - One-shot PWM loads first, then second, stops at second underflow.
// - One-shot PWM output is level at start and end, inverted between.
// - One-shot PWM requests at both underflows, first one software gated.
// - One-shot PWM reload writes apply from the next start.
// - Pulse mode loads on tick after enable, counts to underflow, stops.
// - Pulse mode output is inverted at start, level at underflow.
// - Pulse mode requests at its single underflow.
// - Pulse mode stop at underflow beats external enable.
// - Pulse mode software enable write beats stop at underflow.
// - Pulse mode uses the low 24 bits as one reload value.
// - Writing a reload value never loads the counter directly.
module rpot_timer #(
    parameter int SYNC_STAGES = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic countTick,
    input wire logic extEnablePin,
    input wire rpot_pkg::rpot_bus_req_t busReq,
    output logic [31:0] busRdData,
    output logic outLevel,
    output rpot_pkg::rpot_req_t reqOut
);

    // ------------------------------------------------------------------
    // External enable synchroniser.
    // ------------------------------------------------------------------
    logic [SYNC_STAGES-1:0] extSync_ff;
    logic extStable_ff;
    logic extEnEdge;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            extSync_ff <= '0;
        end else if (clkEn) begin
            extSync_ff <= {extSync_ff[SYNC_STAGES-2:0], extEnablePin};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            extStable_ff <= 1'b0;
        end else if (clkEn && (extSync_ff[1] == extSync_ff[2])) begin
            extStable_ff <= extSync_ff[2];
        end
    end

    assign extEnEdge = (extSync_ff[1] == extSync_ff[2]) && extSync_ff[2] && !extStable_ff;

    // ------------------------------------------------------------------
    // Register writes.
    // ------------------------------------------------------------------
    logic [31:0] reload_ff;
    logic [6:0] ctrl_ff;
    logic reloadWr;
    logic ctrlWr;
    logic swEnWr;
    logic swDisWr;
    rpot_pkg::rpot_mode_t mode;
    logic level;

    assign reloadWr = busReq.wr && (busReq.addr == rpot_pkg::RELOAD_OFS);
    assign ctrlWr = busReq.wr && (busReq.addr == rpot_pkg::CTRL_OFS);
    assign swEnWr = ctrlWr && busReq.wdata[rpot_pkg::CTRL_EN_BIT];
    assign swDisWr = ctrlWr && !busReq.wdata[rpot_pkg::CTRL_EN_BIT];
    assign mode = rpot_pkg::rpot_mode_t'(ctrl_ff[rpot_pkg::CTRL_MODE_LSB +: 2]);
    assign level = ctrl_ff[rpot_pkg::CTRL_LEVEL_BIT];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reload_ff <= rpot_pkg::RELOAD_RST;
        end else if (clkEn && reloadWr) begin
            reload_ff <= busReq.wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= rpot_pkg::CTRL_RST;
        end else if (clkEn && ctrlWr) begin
            ctrl_ff <= busReq.wdata[6:0];
        end
    end

    // ------------------------------------------------------------------
    // Counter control.
    // ------------------------------------------------------------------
    logic run_ff;
    logic pendLoad_ff;
    logic phase_ff;
    logic [23:0] count_ff;
    logic [15:0] secondBuf_ff;
    logic [15:0] shotFirst_ff;
    logic [15:0] shotSecond_ff;
    logic outLevel_ff;
    logic reqEvt;
    logic [23:0] nxt_count;
    logic nxt_phase;
    logic nxt_out;
    logic nxt_run;
    logic nxt_pend;
    logic nxt_reqEvt;
    logic copySecond;
    logic underflow;
    logic startReq;
    logic [15:0] firstVal;
    logic [15:0] secondVal;

    assign firstVal = reload_ff[rpot_pkg::FIRST_LSB +: rpot_pkg::HALF_W];
    assign secondVal = reload_ff[rpot_pkg::SECOND_LSB +: rpot_pkg::HALF_W];
    assign underflow = run_ff && !pendLoad_ff && countTick && (count_ff == 24'h000000);
    // Software disable wins over external enable in the same cycle.
    assign startReq = swEnWr || (extEnEdge && !swDisWr);

    always_comb begin
        nxt_count = count_ff;
        nxt_phase = phase_ff;
        nxt_out = outLevel_ff;
        nxt_run = run_ff;
        nxt_pend = pendLoad_ff;
        nxt_reqEvt = 1'b0;
        copySecond = 1'b0;
        if (pendLoad_ff && countTick) begin
            nxt_pend = 1'b0;
            nxt_phase = 1'b0;
            case (mode)
                rpot_pkg::RPOT_MODE_PWM: begin
                    copySecond = 1'b1;
                    if (firstVal == rpot_pkg::DUTY_EDGE) begin
                        nxt_count = {8'h00, secondVal};
                        nxt_phase = 1'b1;
                        nxt_out = level;
                    end else begin
                        nxt_count = {8'h00, firstVal};
                        nxt_out = !level;
                    end
                end
                rpot_pkg::RPOT_MODE_SHOT_PWM: begin
                    if (firstVal == rpot_pkg::DUTY_EDGE) begin
                        nxt_count = {8'h00, secondVal};
                        nxt_phase = 1'b1;
                        nxt_out = !level;
                    end else if (secondVal == rpot_pkg::DUTY_EDGE) begin
                        nxt_count = {8'h00, firstVal};
                        nxt_out = !level;
                    end else begin
                        nxt_count = {8'h00, firstVal};
                        nxt_out = level;
                    end
                end
                default: begin
                    nxt_count = reload_ff[rpot_pkg::PULSE_W-1:0];
                    nxt_out = !level;
                end
            endcase
        end else if (underflow) begin
            case (mode)
                rpot_pkg::RPOT_MODE_PWM: begin
                    if (!phase_ff && secondBuf_ff != rpot_pkg::DUTY_EDGE) begin
                        nxt_count = {8'h00, secondBuf_ff};
                        nxt_phase = 1'b1;
                        nxt_out = level;
                    end else if (phase_ff && firstVal == rpot_pkg::DUTY_EDGE) begin
                        copySecond = 1'b1;
                        nxt_count = {8'h00, secondVal};
                        nxt_out = level;
                        nxt_reqEvt = 1'b1;
                    end else begin
                        copySecond = 1'b1;
                        nxt_count = {8'h00, firstVal};
                        nxt_phase = 1'b0;
                        nxt_out = !level;
                        nxt_reqEvt = 1'b1;
                    end
                end
                rpot_pkg::RPOT_MODE_SHOT_PWM: begin
                    if (!phase_ff && shotSecond_ff != rpot_pkg::DUTY_EDGE) begin
                        nxt_count = {8'h00, shotSecond_ff};
                        nxt_phase = 1'b1;
                        nxt_out = !level;
                        nxt_reqEvt = ctrl_ff[rpot_pkg::CTRL_FIRSTREQ_BIT];
                    end else begin
                        nxt_run = 1'b0;
                        nxt_out = level;
                        nxt_reqEvt = 1'b1;
                    end
                end
                default: begin
                    nxt_run = 1'b0;
                    nxt_out = level;
                    nxt_reqEvt = 1'b1;
                end
            endcase
        end else if (run_ff && countTick && !pendLoad_ff) begin
            nxt_count = count_ff - 24'h000001;
        end
        // A start while stopped, or an enable write at stop, relaunches the counter.
        if (startReq && (!run_ff || !nxt_run)) begin
            if (swEnWr || !underflow) begin
                nxt_run = 1'b1;
                nxt_pend = 1'b1;
            end else begin
                nxt_run = 1'b0;
            end
        end
        if (swDisWr) begin
            nxt_run = 1'b0;
            nxt_pend = 1'b0;
            nxt_reqEvt = 1'b0;
        end
        if (ctrlWr && !nxt_run) begin
            nxt_out = busReq.wdata[rpot_pkg::CTRL_LEVEL_BIT];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            run_ff <= 1'b0;
            pendLoad_ff <= 1'b0;
            phase_ff <= 1'b0;
            count_ff <= 24'h000000;
            outLevel_ff <= 1'b0;
            reqEvt <= 1'b0;
        end else if (clkEn) begin
            run_ff <= nxt_run;
            pendLoad_ff <= nxt_pend;
            phase_ff <= nxt_phase;
            count_ff <= nxt_count;
            outLevel_ff <= nxt_out;
            reqEvt <= nxt_reqEvt;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            secondBuf_ff <= 16'h0000;
        end else if (clkEn && copySecond) begin
            secondBuf_ff <= secondVal;
        end
    end

    // The one-shot PWM pair is frozen at start so later writes wait for the next run.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shotFirst_ff <= 16'h0000;
            shotSecond_ff <= 16'h0000;
        end else if (clkEn && pendLoad_ff && countTick) begin
            shotFirst_ff <= firstVal;
            shotSecond_ff <= secondVal;
        end
    end

    // ------------------------------------------------------------------
    // Request outputs.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reqOut <= '0;
        end else if (clkEn) begin
            reqOut.irq <= reqEvt && ctrl_ff[rpot_pkg::CTRL_IRQEN_BIT];
            reqOut.dma <= reqEvt && ctrl_ff[rpot_pkg::CTRL_DMAEN_BIT];
        end
    end

    assign outLevel = outLevel_ff;

    // ------------------------------------------------------------------
    // Register reads.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busRdData <= 32'h00000000;
        end else if (clkEn) begin
            busRdData <= 32'h00000000;
            if (busReq.rd) begin
                if (busReq.addr == rpot_pkg::RELOAD_OFS) begin
                    busRdData <= reload_ff;
                end else if (busReq.addr == rpot_pkg::CTRL_OFS) begin
                    busRdData <= {25'h0, ctrl_ff[6:1], run_ff};
                end else if (busReq.addr == rpot_pkg::COUNT_OFS) begin
                    busRdData <= {8'h00, count_ff};
                end else if (busReq.addr == rpot_pkg::STATUS_OFS) begin
                    busRdData <= {29'h0, outLevel_ff, phase_ff, run_ff};
                end
            end
        end
    end

endmodule
`default_nettype wire

// file: shared/rpot_pkg.sv
`default_nettype none
package rpot_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] RELOAD_OFS = 8'h00;
    localparam logic [7:0] CTRL_OFS = 8'h04;
    localparam logic [7:0] COUNT_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;

    localparam logic [31:0] RELOAD_RST = 32'h00000000;
    localparam int FIRST_LSB = 0;
    localparam int SECOND_LSB = 16;
    localparam int HALF_W = 16;
    localparam int PULSE_W = 24;
    localparam logic [15:0] DUTY_EDGE = 16'hFFFF;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_LEVEL_BIT = 3;
    localparam int CTRL_FIRSTREQ_BIT = 4;
    localparam int CTRL_IRQEN_BIT = 5;
    localparam int CTRL_DMAEN_BIT = 6;
    localparam logic [6:0] CTRL_RST = 7'h00;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_PHASE_BIT = 1;
    localparam int STAT_OUT_BIT = 2;

    typedef enum logic [1:0] {
        RPOT_MODE_PWM = 2'b00,
        RPOT_MODE_SHOT_PWM = 2'b01,
        RPOT_MODE_PULSE = 2'b10,
        RPOT_MODE_RSVD = 2'b11
    } rpot_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } rpot_bus_req_t;

    typedef struct packed {
        logic irq;
        logic dma;
    } rpot_req_t;

endpackage
`default_nettype wire

// file: dv/rpot_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rpot_timer_monitor #(
    parameter int SYNC_STAGES = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic countTick,
    input wire logic extEnablePin,
    input wire rpot_pkg::rpot_bus_req_t busReq,
    input wire logic [31:0] busRdData,
    input wire logic outLevel,
    input wire rpot_pkg::rpot_req_t reqOut
);
    logic [31:0] reloadSh_ff;
    logic [6:0] ctrlSh_ff;
    logic mapped;
    assign mapped = busReq.addr inside {rpot_pkg::RELOAD_OFS, rpot_pkg::CTRL_OFS,
        rpot_pkg::COUNT_OFS, rpot_pkg::STATUS_OFS};
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reloadSh_ff <= rpot_pkg::RELOAD_RST;
            ctrlSh_ff <= rpot_pkg::CTRL_RST;
        end else if (clkEn && busReq.wr) begin
            if (busReq.addr == rpot_pkg::RELOAD_OFS)
                reloadSh_ff <= busReq.wdata;
            if (busReq.addr == rpot_pkg::CTRL_OFS)
                ctrlSh_ff <= busReq.wdata[6:0];
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_rd_idle_zero: assert property ($past(clkEn) && !$past(busReq.rd) |-> busRdData == 32'h0)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (busReq.rd && !mapped |=> busRdData == 32'h0)
        else $error("unmapped read not zero");
    a_reload_back: assert property (busReq.rd && busReq.addr == rpot_pkg::RELOAD_OFS
        |=> busRdData == $past(reloadSh_ff))
        else $error("reload read differs from last write");
    a_ctrl_back: assert property (busReq.rd && busReq.addr == rpot_pkg::CTRL_OFS
        |=> busRdData[6:1] == $past(ctrlSh_ff[6:1]))
        else $error("control read differs from last write");
    a_irq_from_tick: assert property (reqOut.irq |-> $past(countTick, 2))
        else $error("interrupt request without underflow tick");
    a_dma_from_tick: assert property (reqOut.dma |-> $past(countTick, 2))
        else $error("transfer request without underflow tick");
    a_irq_gated: assert property (reqOut.irq |-> $past(ctrlSh_ff[5], 2) || $past(ctrlSh_ff[5], 3))
        else $error("interrupt request while disabled");
    a_out_cause: assert property ($changed(outLevel) |-> $past(countTick) || $past(countTick, 2)
        || $past(busReq.wr) || $past(busReq.wr, 2))
        else $error("output changed without tick or write");
endmodule
bind rpot_timer rpot_timer_monitor #(.SYNC_STAGES(SYNC_STAGES)) rpot_timer_monitor_i (
    .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .countTick(countTick),
    .extEnablePin(extEnablePin), .busReq(busReq), .busRdData(busRdData),
    .outLevel(outLevel), .reqOut(reqOut));
`default_nettype wire

// file: dv/rpot_load.sv
`timescale 1ns/1ps
`default_nettype none
module rpot_load (
    input wire logic core_clk,
    input wire logic outLevel,
    input wire logic countTick,
    input wire logic fire,
    output logic extEnablePin,
    output logic [15:0] highTicks,
    output logic [15:0] lowTicks
);
    logic [15:0] run = 16'h0000;
    logic [3:0] hold = 4'h0;
    logic prevLvl = 1'b0;
    // Enable pin pulse and run lengths of the output in count ticks.
    always @(posedge core_clk) begin
        hold <= fire ? 4'h6 : (hold != 4'h0 ? hold - 4'h1 : 4'h0);
        prevLvl <= outLevel;
        if (outLevel != prevLvl) begin
            if (prevLvl)
                highTicks <= run;
            else
                lowTicks <= run;
            run <= {15'h0, countTick};
        end else
            run <= run + {15'h0, countTick};
    end
    assign extEnablePin = (hold != 4'h0);
endmodule
`default_nettype wire

// file: dv/test_rpot_timer.sv
`timescale 1ns/1ps
`default_nettype none
module test_rpot_timer;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic countTick = 1'b0;
    logic fire = 1'b0;
    logic extEnablePin;
    rpot_pkg::rpot_bus_req_t busReq = '0;
    logic [31:0] busRdData;
    logic outLevel;
    rpot_pkg::rpot_req_t reqOut;
    logic [15:0] highTicks;
    logic [15:0] lowTicks;
    logic [31:0] rdQ[$];
    logic rdSeen = 1'b0;
    logic lvl;
    logic [31:0] r;
    int n_errors = 0;
    int n_checks = 0;
    int irqs = 0;
    int dmas = 0;
    int seed = 76;
    logic clkEn = 1'b1;
    rpot_timer #(.SYNC_STAGES(3)) rpot_timer_i (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
        .countTick(countTick), .extEnablePin(extEnablePin), .busReq(busReq),
        .busRdData(busRdData), .outLevel(outLevel), .reqOut(reqOut));
    rpot_load rpot_load_i (.core_clk(core_clk), .outLevel(outLevel), .countTick(countTick),
        .fire(fire), .extEnablePin(extEnablePin), .highTicks(highTicks), .lowTicks(lowTicks));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        countTick <= !rst && ($random(seed) % 3 == 0);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Scoreboard: read results are compared against the oldest note.
    always @(posedge core_clk) begin
        rdSeen <= busReq.rd;
        if (reqOut.irq === 1'b1)
            irqs++;
        if (reqOut.dma === 1'b1)
            dmas++;
        if (rdSeen)
            check(busRdData, rdQ.pop_front());
    end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        busReq <= '{wr: wr, rd: !wr, addr: a, wdata: d};
        if (!wr)
            rdQ.push_back(d);
        @(posedge core_clk);
        busReq <= '0;
    endtask
    task automatic wait_irq(input int n);
        for (int k = 0; k < 3000 && irqs < n; k++)
            @(posedge core_clk);
        if (irqs < n) begin
            check(32'(irqs), 32'(n));
            report_and_stop();
        end
        repeat (4) @(posedge core_clk);
    endtask
    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        bus(0, rpot_pkg::RELOAD_OFS, rpot_pkg::RELOAD_RST);
        bus(0, rpot_pkg::CTRL_OFS, 32'h00000000);
        bus(0, 8'h10, 32'h00000000);
        for (int i = 0; i < 3; i++) begin
            r = $random(seed) & 32'h7FFE7FFE;
            bus(1, rpot_pkg::RELOAD_OFS, r);
            bus(0, rpot_pkg::RELOAD_OFS, r);
        end
        bus(1, rpot_pkg::RELOAD_OFS, 32'h00000005);
        bus(1, rpot_pkg::CTRL_OFS, 32'h00000065);
        wait_irq(1);
        check({16'h0000, highTicks}, 32'h00000006);
        check(32'(dmas), 32'h00000001);
        check({31'h0, outLevel}, 32'h00000000);
        bus(0, rpot_pkg::CTRL_OFS, 32'h00000064);
        bus(1, rpot_pkg::RELOAD_OFS, 32'h00010009);
        bus(1, rpot_pkg::CTRL_OFS, 32'h0000003B);
        repeat (8) @(posedge core_clk);
        bus(1, rpot_pkg::RELOAD_OFS, 32'h00070007);
        wait_irq(3);
        check({16'h0000, lowTicks}, 32'h00000002);
        check({16'h0000, highTicks}, 32'h0000000A);
        check({31'h0, outLevel}, 32'h00000001);
        bus(0, rpot_pkg::CTRL_OFS, 32'h0000003A);
        bus(1, rpot_pkg::RELOAD_OFS, 32'h00040002);
        bus(1, rpot_pkg::CTRL_OFS, 32'h00000029);
        wait_irq(5);
        check({16'h0000, lowTicks}, 32'h00000003);
        check({16'h0000, highTicks}, 32'h00000005);
        bus(1, rpot_pkg::CTRL_OFS, 32'h00000028);
        @(posedge core_clk);
        lvl = outLevel;
        check({31'h0, lvl}, 32'h00000001);
        repeat (60) @(posedge core_clk);
        check({31'h0, outLevel}, {31'h0, lvl});
        check(32'(irqs), 32'h00000005);
        bus(1, rpot_pkg::RELOAD_OFS, 32'h00000003);
        bus(1, rpot_pkg::CTRL_OFS, 32'h00000064);
        @(posedge core_clk);
        busReq <= '{wr: 1'b1, rd: 1'b0, addr: rpot_pkg::CTRL_OFS, wdata: 32'h00000064};
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (14) @(posedge core_clk);
        busReq <= '0;
        repeat (40) @(posedge core_clk);
        check(32'(irqs), 32'h00000005);
        clkEn <= 1'b0;
        bus(1, rpot_pkg::RELOAD_OFS, 32'h00000009);
        clkEn <= 1'b1;
        bus(0, rpot_pkg::RELOAD_OFS, 32'h00000003);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        wait_irq(6);
        check({16'h0000, highTicks}, 32'h00000004);
        bus(1, rpot_pkg::CTRL_OFS, 32'h00000008);
        bus(1, rpot_pkg::RELOAD_OFS, 32'hFFFF0004);
        bus(1, rpot_pkg::CTRL_OFS, 32'h0000002B);
        wait_irq(7);
        check({16'h0000, lowTicks}, 32'h00000005);
        check({31'h0, outLevel}, 32'h00000001);
        bus(1, rpot_pkg::RELOAD_OFS, 32'hFFFF0003);
        bus(1, rpot_pkg::CTRL_OFS, 32'h00000029);
        wait_irq(9);
        check({31'h0, outLevel}, 32'h00000000);
        bus(1, rpot_pkg::CTRL_OFS, 32'h00000028);
        report_and_stop();
    end
endmodule
`default_nettype wire
